// ===== rtl/ptp_pkg.sv
// package: constants and types for the pwm trip protection block
package ptp_pkg;
  // number of comparator units feeding the pwm crossbar
  localparam int NUM_CMP = 6;
  // number of trip lines (trip 1..trip 15, index 0 unused)
  localparam int NUM_TRIP = 16;
  // trip line numbers that the pwm crossbar may drive
  localparam int XBAR_TRIP_LO = 4;
  localparam int XBAR_TRIP_HI = 12;
  // trip line fed directly by input crossbar line one
  localparam int TRIP_LINE_ONE = 1;
  // pwm crossbar mux/position width
  localparam int MUX_W = 4;
  localparam int POS_W = 2;
  localparam int TRIP_SEL_W = 4;
  // least persistence of a comparator trip, in time-base periods
  localparam int CMP_PERSIST_CYC = 3;
  // pwm crossbar positions
  localparam logic [1:0] POS_HIGH = 2'h0;
  localparam logic [1:0] POS_OR = 2'h1;
  localparam logic [1:0] POS_LOW_OR_PIN = 2'h2;
  // trip actions per output
  typedef enum logic [1:0] {
    PTP_ACT_HIZ = 2'h0,
    PTP_ACT_HIGH = 2'h1,
    PTP_ACT_LOW = 2'h2,
    PTP_ACT_NONE = 2'h3
  } ptp_act_e;
  // compare event conditions
  typedef enum logic [2:0] {
    PTP_CND_OFF = 3'h0,
    PTP_CND_LOW_LOW = 3'h1,
    PTP_CND_LOW_HIGH = 3'h2,
    PTP_CND_HIGH_LOW = 3'h3,
    PTP_CND_HIGH_HIGH = 3'h4
  } ptp_cnd_e;
  // cycle trip release points
  localparam logic [1:0] REL_ZERO = 2'h0;
  localparam logic [1:0] REL_PERIOD = 2'h1;
  localparam logic [1:0] REL_EITHER = 2'h2;
endpackage

// ===== rtl/ptp_top.sv
// module: trip routing, digital compare and trip-zone forcing of one pwm channel
`timescale 1ns/100ps
// Operation
// - comparator trips reach trip stage via compare
// - mux zero position zero routes comparator one high
// - crossbar output assignable to trips four..twelve
// - four compare events, two per output
// - only second events may cause cycle trips
// - each event uses selectable high/low inputs
// - high-input-high condition asserts while input high
// - cycle trip forces both outputs to action
// - trips set sticky flags and interrupt flag
// - single shot trip holds outputs until cleared
// - pins routable to crossbar or trip lines
// - input crossbar line one feeds trip one
// - pin trips active low, falling edge trips
// - separate actions for output a and b
// - single shot releases after input gone and cleared
// - cycle trip releases at zero/period/either event
module ptp_top
  import ptp_pkg::*;
#(
  parameter int NUM_PIN = 16,
  parameter int PIN_SEL_W = 4
)(
  input wire logic core_clk,
  input wire logic rst_b,
  // comparator subsystem trip outputs
  input wire logic [NUM_CMP-1:0] comparator_high_trip,
  input wire logic [NUM_CMP-1:0] comparator_low_trip,
  // general-purpose pins, already synchronous
  input wire logic [NUM_PIN-1:0] gpio_in,
  // pwm outputs before protection
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  // time-base counter events
  input wire logic counter_zero_event,
  input wire logic counter_period_event,
  // input crossbar: pin selects for lines one..six
  input wire logic [6*PIN_SEL_W-1:0] input_xbar_sel,
  // pin routed by input crossbar line one onto trip one
  // pwm crossbar: mux, position and target trip line
  input wire logic [MUX_W-1:0] pwm_xbar_mux,
  input wire logic [POS_W-1:0] pwm_xbar_pos,
  input wire logic [TRIP_SEL_W-1:0] pwm_xbar_trip,
  // compare high/low input selects for a and b
  input wire logic [TRIP_SEL_W-1:0] compare_a_high_input,
  input wire logic [TRIP_SEL_W-1:0] compare_a_low_input,
  input wire logic [TRIP_SEL_W-1:0] compare_b_high_input,
  input wire logic [TRIP_SEL_W-1:0] compare_b_low_input,
  // conditions: a1, a2, b1, b2
  input wire logic [4*3-1:0] event_cond,
  // trip actions: a, b, then events a1 a2 b1 b2
  input wire logic [1:0] output_a_trip_action,
  input wire logic [1:0] output_b_trip_action,
  input wire logic [4*2-1:0] event_action,
  // enables: cycle trip from a2/b2, single shot from trip one
  input wire logic cyc_src_a2_en,
  input wire logic cyc_src_b2_en,
  input wire logic shot_src_trip1_en,
  input wire logic [1:0] cyc_release_sel,
  // write-one-to-clear strobes
  input wire logic clr_cyc_flag,
  input wire logic clr_shot_flag,
  input wire logic clr_int_flag,
  // protected outputs with enables
  output logic pwm_output_a,
  output logic pwm_output_a_oe,
  output logic pwm_output_b,
  output logic pwm_output_b_oe,
  // status
  output logic cyc_flag,
  output logic shot_flag,
  output logic int_flag,
  output logic [3:0] event_status,
  output logic trip_irq
);

  // elaboration check on pin select width
  if ((1 << PIN_SEL_W) < NUM_PIN)
  begin : g_bad_sel
    $error("pin select too narrow");
  end

  // local shape of the crossbars and of the compare stage
  localparam int NUM_IN_LINE = 6; // input crossbar lines
  localparam int NUM_EVT = 4; // compare events a1, a2, b1, b2
  localparam int COND_W = 3; // width of one event condition field
  localparam int ACT_W = 2; // width of one action field
  localparam int EVT_A1 = 0; // first a event, never a cycle trip source
  localparam int EVT_A2 = 1; // second a event, may cause a cycle trip
  localparam int EVT_B1 = 2; // first b event, never a cycle trip source
  localparam int EVT_B2 = 3; // second b event, may cause a cycle trip
  // trip lines after reset: line one idles high like its active-low pin
  localparam logic [NUM_TRIP-1:0] TRIP_IDLE = NUM_TRIP'(1) << TRIP_LINE_ONE;

  // elaboration check on trip line numbering and crossbar mux width
  if ((1 << TRIP_SEL_W) < NUM_TRIP || XBAR_TRIP_HI >= NUM_TRIP || (1 << MUX_W) <= 2 * NUM_CMP)
  begin : g_bad_shape
    $error("trip or mux select too narrow");
  end

  // input crossbar lines one..six; line one also feeds trip one
  // lines two..six only reach the trip lines through odd pwm crossbar muxes
  logic [NUM_IN_LINE:1] in_line; // pins picked by the input crossbar
  genvar gi;
  for (gi = 1; gi <= NUM_IN_LINE; gi++)
  begin : g_inxbar
    assign in_line[gi] = gpio_in[input_xbar_sel[(gi-1)*PIN_SEL_W +: PIN_SEL_W]];
  end

  // pwm crossbar mux selection
  logic [MUX_W-2:0] cmp_idx;
  logic mux_odd;
  logic xbar_sig;
  logic [NUM_CMP-1:0] cmp_or;
  assign cmp_idx = pwm_xbar_mux[MUX_W-1:1];
  assign mux_odd = pwm_xbar_mux[0];
  assign cmp_or = comparator_high_trip | comparator_low_trip;
  logic line_ok; // odd mux index names an existing input crossbar line
  assign line_ok = cmp_idx < (MUX_W-1)'(NUM_IN_LINE);
  // even mux: high trip / or; odd mux: low trip / input line
  // mux codes past the comparators and unused positions select nothing
  assign xbar_sig = (pwm_xbar_mux >= MUX_W'(2*NUM_CMP)) ? 1'b0 :
    (!mux_odd && pwm_xbar_pos == POS_HIGH) ? comparator_high_trip[cmp_idx] :
    (!mux_odd && pwm_xbar_pos == POS_OR) ? cmp_or[cmp_idx] :
    (mux_odd && pwm_xbar_pos == POS_HIGH) ? comparator_low_trip[cmp_idx] :
    (mux_odd && pwm_xbar_pos == POS_OR && line_ok) ? in_line[cmp_idx+1] :
    1'b0;

  // trip lines; crossbar only onto trips four..twelve
  logic [NUM_TRIP-1:0] trip_d;
  logic [NUM_TRIP-1:0] trip_q;
  genvar gt;
  for (gt = 0; gt < NUM_TRIP; gt++)
  begin : g_trip
    if (gt >= XBAR_TRIP_LO && gt <= XBAR_TRIP_HI)
    begin : g_x
      assign trip_d[gt] = xbar_sig && (pwm_xbar_trip == TRIP_SEL_W'(gt));
    end
    else if (gt == TRIP_LINE_ONE)
    begin : g_one
      assign trip_d[gt] = in_line[1];
    end
    else
    begin : g_z
      // other trip lines have no source in this channel
      assign trip_d[gt] = 1'b0;
    end
  end

  // trip lines synced to the time-base clock; comparators need 3 periods
  // reset to idle levels, so line one does not look tripped after reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      trip_q <= TRIP_IDLE;
    else
      trip_q <= trip_d;
  end

  // compare events: comparator trips only arrive via these
  // a1 and a2 share the a inputs, b1 and b2 the b inputs
  logic [TRIP_SEL_W-1:0] hsel [NUM_EVT]; // high input select per event
  logic [TRIP_SEL_W-1:0] lsel [NUM_EVT]; // low input select per event
  logic [NUM_EVT-1:0] evt; // live compare events
  assign hsel[EVT_A1] = compare_a_high_input;
  assign hsel[EVT_A2] = compare_a_high_input;
  assign hsel[EVT_B1] = compare_b_high_input;
  assign hsel[EVT_B2] = compare_b_high_input;
  assign lsel[EVT_A1] = compare_a_low_input;
  assign lsel[EVT_A2] = compare_a_low_input;
  assign lsel[EVT_B1] = compare_b_low_input;
  assign lsel[EVT_B2] = compare_b_low_input;
  genvar ge;
  for (ge = 0; ge < NUM_EVT; ge++)
  begin : g_evt
    logic hi; // selected high input level
    logic lo; // selected low input level
    ptp_cnd_e cnd; // condition of this event
    assign hi = trip_q[hsel[ge]];
    assign lo = trip_q[lsel[ge]];
    assign cnd = ptp_cnd_e'(event_cond[ge*COND_W +: COND_W]);
    assign evt[ge] = (cnd == PTP_CND_HIGH_HIGH) ? hi :
      (cnd == PTP_CND_HIGH_LOW) ? !hi :
      (cnd == PTP_CND_LOW_HIGH) ? lo :
      (cnd == PTP_CND_LOW_LOW) ? !lo : 1'b0;
  end

  // cycle trip only from second events; first events never reach it
  logic cyc_src; // cycle trip source this cycle
  assign cyc_src = (cyc_src_a2_en && evt[EVT_A2]) ||
    (cyc_src_b2_en && evt[EVT_B2]);

  // single shot from trip one: pin is active low, falling edge trips
  // the pin level is taken from trip_q, one clock after the pin
  logic pin_prev_q;
  logic shot_src;
  logic pin_low;
  assign pin_low = !trip_q[TRIP_LINE_ONE];
  assign shot_src = shot_src_trip1_en && pin_low && pin_prev_q;

  // previous pin level, for the falling edge
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pin_prev_q <= 1'b1;
    else
      pin_prev_q <= trip_q[TRIP_LINE_ONE];
  end

  // cycle trip latch, released at chosen boundary
  // release code three never releases; a source still active sets again
  logic rel_evt;
  logic cyc_act_q;
  logic cyc_act_d;
  assign rel_evt = (cyc_release_sel == REL_ZERO) ? counter_zero_event :
    (cyc_release_sel == REL_PERIOD) ? counter_period_event :
    (cyc_release_sel == REL_EITHER) ? (counter_zero_event || counter_period_event) : 1'b0;
  assign cyc_act_d = cyc_src ? 1'b1 : (rel_evt ? 1'b0 : cyc_act_q);

  // single shot latch: held until flag cleared with input gone
  // a clear while the pin is still low clears the flag only
  logic shot_act_q;
  logic shot_act_d;
  assign shot_act_d = shot_src ? 1'b1 :
    ((clr_shot_flag && !pin_low) ? 1'b0 : shot_act_q);

  // sticky flags; a set wins over a clear
  // the interrupt flag has its own clear strobe
  logic cyc_flag_d;
  logic shot_flag_d;
  logic int_flag_d;
  assign cyc_flag_d = cyc_src || (cyc_flag && !clr_cyc_flag);
  assign shot_flag_d = shot_src || (shot_flag && !clr_shot_flag);
  assign int_flag_d = cyc_src || shot_src || (int_flag && !clr_int_flag);

  // action resolution: trip actions first, else event actions
  logic force_on;
  ptp_act_e act_a;
  ptp_act_e act_b;
  ptp_act_e evt_act_a;
  ptp_act_e evt_act_b;
  assign force_on = cyc_act_q || shot_act_q || cyc_src || shot_src;
  // a trip force overrides event actions; a first event beats a second
  assign evt_act_a = evt[EVT_A1] ? ptp_act_e'(event_action[EVT_A1*ACT_W +: ACT_W]) :
    evt[EVT_A2] ? ptp_act_e'(event_action[EVT_A2*ACT_W +: ACT_W]) : PTP_ACT_NONE;
  assign evt_act_b = evt[EVT_B1] ? ptp_act_e'(event_action[EVT_B1*ACT_W +: ACT_W]) :
    evt[EVT_B2] ? ptp_act_e'(event_action[EVT_B2*ACT_W +: ACT_W]) : PTP_ACT_NONE;
  assign act_a = force_on ? ptp_act_e'(output_a_trip_action) : evt_act_a;
  assign act_b = force_on ? ptp_act_e'(output_b_trip_action) : evt_act_b;

  // output value and enable per action
  // hiz drops the enable and parks the level low
  logic a_d;
  logic a_oe_d;
  logic b_d;
  logic b_oe_d;
  assign a_d = (act_a == PTP_ACT_HIGH) ? 1'b1 :
    (act_a == PTP_ACT_NONE) ? pwm_in_a : 1'b0;
  assign a_oe_d = (act_a != PTP_ACT_HIZ);
  assign b_d = (act_b == PTP_ACT_HIGH) ? 1'b1 :
    (act_b == PTP_ACT_NONE) ? pwm_in_b : 1'b0;
  assign b_oe_d = (act_b != PTP_ACT_HIZ);

  // state and registered outputs
  // trip_irq follows the next interrupt flag, so both change together
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cyc_act_q <= 1'b0;
      shot_act_q <= 1'b0;
      cyc_flag <= 1'b0;
      shot_flag <= 1'b0;
      int_flag <= 1'b0;
      trip_irq <= 1'b0;
      event_status <= '0;
      pwm_output_a <= 1'b0;
      pwm_output_a_oe <= 1'b0;
      pwm_output_b <= 1'b0;
      pwm_output_b_oe <= 1'b0;
    end
    else
    begin
      cyc_act_q <= cyc_act_d;
      shot_act_q <= shot_act_d;
      cyc_flag <= cyc_flag_d;
      shot_flag <= shot_flag_d;
      int_flag <= int_flag_d;
      trip_irq <= int_flag_d;
      event_status <= evt;
      pwm_output_a <= a_d;
      pwm_output_a_oe <= a_oe_d;
      pwm_output_b <= b_d;
      pwm_output_b_oe <= b_oe_d;
    end
  end

endmodule // ptp_top

// ===== test/ptp_trip_source.sv
// model of the comparator trip outputs and the trip pins
`timescale 1ns/100ps
module ptp_trip_source
  import ptp_pkg::*;
(
  input wire logic core_clk,
  input wire logic fire,
  input wire logic pin_trip,
  output logic [NUM_CMP-1:0] comparator_high_trip,
  output logic [NUM_CMP-1:0] comparator_low_trip,
  output logic [15:0] gpio_in
);
  int cnt = 0; // cycles left on the comparator trip
  // each request holds the trip for the least persistence only
  always @(negedge core_clk)
    cnt <= fire ? CMP_PERSIST_CYC : (cnt > 0 ? cnt - 1 : 0);
  assign comparator_high_trip = NUM_CMP'(cnt > 0);
  assign comparator_low_trip = '0;
  // idle pins sit high; pin twelve low while tripping
  assign gpio_in = 16'hffff ^ (16'(pin_trip) << 12);
endmodule // ptp_trip_source

// ===== test/ptp_top_properties.sv
// concurrent checks on the ports of the trip protection block
`timescale 1ns/100ps
module ptp_top_properties
  import ptp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cyc_src_a2_en,
  input wire logic cyc_src_b2_en,
  input wire logic [1:0] output_a_trip_action,
  input wire logic clr_cyc_flag,
  input wire logic clr_shot_flag,
  input wire logic clr_int_flag,
  input wire logic pwm_output_a,
  input wire logic pwm_output_a_oe,
  input wire logic cyc_flag,
  input wire logic shot_flag,
  input wire logic int_flag,
  input wire logic [3:0] event_status,
  input wire logic trip_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  irq_mirror_a: assert property (trip_irq == int_flag)
    else $error("trip_irq differs from int_flag");
  int_clear_a: assert property ($fell(int_flag) |-> $past(clr_int_flag))
    else $error("int_flag dropped without clear");
  cyc_clear_a: assert property ($fell(cyc_flag) |-> $past(clr_cyc_flag))
    else $error("cyc_flag dropped without clear");
  shot_clear_a: assert property ($fell(shot_flag) |-> $past(clr_shot_flag))
    else $error("shot_flag dropped without clear");
  cyc_source_a: assert property ($rose(cyc_flag) |->
    ($past(event_status[1]) || event_status[1]) && cyc_src_a2_en
    || ($past(event_status[3]) || event_status[3]) && cyc_src_b2_en)
    else $error("cycle trip without a second event");
  force_low_a: assert property ($rose(cyc_flag) && output_a_trip_action == PTP_ACT_LOW
    |-> !pwm_output_a && pwm_output_a_oe) else $error("output a not forced low");
  shot_hold_a: assert property ($rose(shot_flag) && output_a_trip_action == PTP_ACT_LOW
    ##1 (!clr_shot_flag)[*3] |-> !pwm_output_a) else $error("single shot not held");
  int_cause_a: assert property ($rose(int_flag) |-> cyc_flag || shot_flag)
    else $error("interrupt without trip flag");
endmodule // ptp_top_properties

// ===== test/tb.sv
// self-checking testbench of the trip protection block
`timescale 1ns/100ps
module tb
  import ptp_pkg::*;
;
  logic core_clk, rst_b, pwm_in_a, pwm_in_b, fire, pin_trip, cyc_src_a2_en, cyc_src_b2_en;
  logic counter_zero_event, counter_period_event, shot_src_trip1_en;
  logic clr_cyc_flag, clr_shot_flag, clr_int_flag, cyc_flag, shot_flag, int_flag, trip_irq;
  logic pwm_output_a, pwm_output_a_oe, pwm_output_b, pwm_output_b_oe;
  logic [1:0] output_a_trip_action, output_b_trip_action, cyc_release_sel, pwm_xbar_pos;
  logic [3:0] pwm_xbar_mux, pwm_xbar_trip, compare_a_high_input, compare_a_low_input;
  logic [3:0] event_status, compare_b_high_input, compare_b_low_input;
  logic [23:0] input_xbar_sel;
  logic [11:0] event_cond;
  logic [7:0] event_action;
  logic [NUM_CMP-1:0] comparator_high_trip, comparator_low_trip;
  logic [15:0] gpio_in;
  int errors = 0;
  int checked = 0;
  ptp_trip_source i_src (.core_clk, .fire, .pin_trip, .comparator_high_trip,
    .comparator_low_trip, .gpio_in);
  ptp_top i_dut (.core_clk, .rst_b, .comparator_high_trip, .comparator_low_trip, .gpio_in,
    .pwm_in_a, .pwm_in_b, .counter_zero_event, .counter_period_event, .input_xbar_sel,
    .pwm_xbar_mux, .pwm_xbar_pos, .pwm_xbar_trip, .compare_a_high_input,
    .compare_a_low_input, .compare_b_high_input, .compare_b_low_input,
    .event_cond, .output_a_trip_action, .output_b_trip_action, .event_action,
    .cyc_src_a2_en, .cyc_src_b2_en, .shot_src_trip1_en, .cyc_release_sel, .clr_cyc_flag,
    .clr_shot_flag, .clr_int_flag, .pwm_output_a, .pwm_output_a_oe, .pwm_output_b,
    .pwm_output_b_oe, .cyc_flag, .shot_flag, .int_flag, .event_status, .trip_irq);
  // free-running time-base clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic results();
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // one-cycle counter boundary pulses, period in bit one
  task automatic pulse_ev(input logic [1:0] e);
    {counter_period_event, counter_zero_event} = e;
    tick(1);
    {counter_period_event, counter_zero_event} = 2'h0;
  endtask
  task automatic clear(input logic [2:0] c);
    {clr_cyc_flag, clr_shot_flag, clr_int_flag} = c;
    tick(1);
    {clr_cyc_flag, clr_shot_flag, clr_int_flag} = 3'h0;
    tick(1);
  endtask
  // comparator trip, wrong boundary must not release, right one must
  task automatic cyc_case(input logic [1:0] rel, input logic [1:0] bad, input logic [1:0] good);
    cyc_release_sel = rel;
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    tick(2);
    chk("event_a2", 2'h1, {1'b0, event_status[1]});
    tick(2);
    chk("trip_a", 2'h1, {pwm_output_a, pwm_output_a_oe});
    chk("trip_b", 2'h1, {pwm_output_b, pwm_output_b_oe});
    chk("cyc_irq", 2'h3, {cyc_flag, trip_irq});
    tick(2);
    pulse_ev(bad);
    tick(2);
    chk("held_a", 2'h1, {pwm_output_a, pwm_output_a_oe});
    pulse_ev(good);
    tick(2);
    chk("free_a", 2'h3, {pwm_output_a, pwm_output_a_oe});
    chk("cyc_kept", 2'h3, {cyc_flag, trip_irq});
    clear(3'h5);
    chk("cyc_clr", 2'h0, {cyc_flag, trip_irq});
  endtask
  // pin trip holds until pin is back high and the flag is cleared
  task automatic shot_case();
    {cyc_src_a2_en, shot_src_trip1_en} = 2'h1;
    output_b_trip_action = PTP_ACT_HIZ;
    pin_trip = 1'b1;
    tick(6);
    chk("shot_a", 2'h1, {pwm_output_a, pwm_output_a_oe});
    chk("shot_b_oe", 2'h0, {1'b0, pwm_output_b_oe});
    chk("shot_irq", 2'h3, {shot_flag, trip_irq});
    clear(3'h2);
    chk("early_a", 2'h1, {pwm_output_a, pwm_output_a_oe});
    chk("shot_clr", 2'h0, {1'b0, shot_flag});
    pin_trip = 1'b0;
    pulse_ev(2'h3);
    tick(2);
    chk("kept_a", 2'h1, {pwm_output_a, pwm_output_a_oe});
    clear(3'h3);
    tick(1);
    chk("rel_a", 2'h3, {pwm_output_a, pwm_output_a_oe});
    chk("rel_b", 2'h3, {pwm_output_b, pwm_output_b_oe});
    {cyc_src_a2_en, shot_src_trip1_en} = 2'h2;
  endtask
  // first event through trip twelve must not cause a cycle trip
  task automatic first_case();
    event_cond = 12'h004;
    {pwm_xbar_trip, compare_a_high_input} = 8'hcc;
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    tick(2);
    chk("event_a1", 2'h1, {1'b0, event_status[0]});
    tick(4);
    chk("no_cyc", 2'h0, {1'b0, cyc_flag});
  endtask
  // b2 through the low input trips; then a b1 event action puts output b in hiz
  task automatic b_case();
    {cyc_src_a2_en, cyc_src_b2_en} = 2'h1;
    {pwm_xbar_pos, cyc_release_sel, output_b_trip_action} = {POS_OR, REL_ZERO, PTP_ACT_LOW};
    {compare_b_high_input, compare_b_low_input} = 8'hcc;
    event_cond = 12'h400;
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    tick(2);
    chk("event_b2", 2'h1, {1'b0, event_status[3]});
    chk("trip_b2", 2'h1, {pwm_output_b, pwm_output_b_oe});
    chk("cyc_int", 2'h3, {cyc_flag, int_flag});
    tick(2);
    pulse_ev(2'h1);
    tick(2);
    chk("free_b", 2'h3, {pwm_output_b, pwm_output_b_oe});
    clear(3'h5);
    chk("cyc_int_clr", 2'h0, {cyc_flag, int_flag});
    {event_cond, event_action} = {12'h100, 8'hcf};
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    tick(2);
    chk("event_b1", 2'h1, {1'b0, event_status[2]});
    chk("evt_act_b", 2'h0, {cyc_flag, pwm_output_b_oe});
    tick(4);
    chk("evt_gone_b", 2'h3, {pwm_output_b, pwm_output_b_oe});
  endtask
  initial
  begin
    {rst_b, fire, pin_trip, counter_zero_event, counter_period_event} = 5'h00;
    {clr_cyc_flag, clr_shot_flag, clr_int_flag, shot_src_trip1_en, cyc_src_b2_en} = 5'h00;
    {pwm_in_a, pwm_in_b, cyc_src_a2_en} = 3'h7;
    cyc_release_sel = REL_ZERO;
    input_xbar_sel = 24'h00_000c;
    {pwm_xbar_mux, pwm_xbar_pos} = {4'h0, POS_HIGH};
    {pwm_xbar_trip, compare_a_high_input, compare_a_low_input} = 12'h441;
    {compare_b_high_input, compare_b_low_input} = 8'h00;
    event_cond = 12'h020;
    event_action = 8'hff;
    {output_a_trip_action, output_b_trip_action} = {PTP_ACT_LOW, PTP_ACT_LOW};
    tick(12);
    rst_b = 1'b1;
    tick(2);
    chk("idle_a", 2'h3, {pwm_output_a, pwm_output_a_oe});
    cyc_case(REL_ZERO, 2'h2, 2'h1);
    cyc_case(REL_PERIOD, 2'h1, 2'h2);
    cyc_case(REL_EITHER, 2'h0, 2'h2);
    shot_case();
    first_case();
    b_case();
    results();
  end
  // cut a hang short
  initial
  begin
    repeat (2000) @(posedge core_clk);
    errors++;
    results();
  end
endmodule // tb
bind ptp_top ptp_top_properties i_props (.core_clk, .rst_b, .cyc_src_a2_en, .cyc_src_b2_en,
  .output_a_trip_action, .clr_cyc_flag, .clr_shot_flag, .clr_int_flag, .pwm_output_a,
  .pwm_output_a_oe, .cyc_flag, .shot_flag, .int_flag, .event_status, .trip_irq);
